// file: dv/cpc_far_model.sv
// Purpose: Cache and medium responder for the command block
// Assumes: Cache clears a dirty bit when it acks that block
// Notes: slow stretches every answer to five cycles
`timescale 1ns/1ps
module cpc_far_model (
   // Clock, reset, test control
   input wire logic clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic [3:0] mark,
   // Cache side
   input wire logic wr_req,
   input wire logic [1:0] wr_idx,
   output logic wr_ack,
   output logic [3:0] dirty,
   output logic [3:0] writes,
   // Medium side
   input wire logic med_req,
   output logic med_done
);
   logic [2:0] wc_q;
   logic [2:0] mc_q;
   logic mbusy_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wc_q <= 3'h0;
         wr_ack <= 1'b0;
         dirty <= 4'h0;
         writes <= 4'h0;
      end else begin
         wr_ack <= 1'b0;
         dirty <= dirty | mark;
         if (wr_ack) begin
            dirty <= (dirty | mark) & ~(4'h1 << wr_idx);
            writes <= writes + 4'h1;
         end
         if (wr_req && !wr_ack) begin
            wc_q <= wc_q + 3'h1;
            if (wc_q >= {slow, 2'h0}) begin
               wc_q <= 3'h0;
               wr_ack <= 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mc_q <= 3'h0;
         mbusy_q <= 1'b0;
         med_done <= 1'b0;
      end else begin
         med_done <= 1'b0;
         if (med_req) begin
            mbusy_q <= 1'b1;
         end else if (mbusy_q) begin
            mc_q <= mc_q + 3'h1;
            if (mc_q >= {slow, 2'h0}) begin
               mc_q <= 3'h0;
               mbusy_q <= 1'b0;
               med_done <= 1'b1;
            end
         end
      end
   end
endmodule

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the command block
// Assumes: Four cache blocks, capacity bytes accepted every cycle, every other cycle while slow
// Notes: Outputs are sampled on the falling edge
`timescale 1ns/1ps
module tb_top import cpc_pkg::*;;
   logic clk = 1'b0;
   logic nrst, cdb_valid, cdb_ready, medium_present, wcd, slow;
   logic cap_valid, sts_valid, med_req, med_done, unit_ready, need_ok;
   logic cwr_req, cwr_ack, wcd_c, wmd, wr_good;
   logic [79:0] cdb;
   logic [7:0] cap_byte, sts_code, asc, ascq, power_perf;
   logic [3:0] sense_key, pwr_cond, dirty, mark, writes;
   logic [1:0] med_act, pwr_rank, cwr_idx;
   logic [7:0] caps [$];
   logic cap_rdy = 1'b1;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   localparam logic [63:0] CAPW = 64'h1A2B3C4D_00000200;
   logic [3:0] rsv [10] = '{4'h4, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC,
      4'hD, 4'hE, 4'hF};
   always #50 clk = ~clk;
   cpc_top #(.NBLK(4)) cpc_top_i (.clk(clk), .nrst(nrst),
      .cdb_valid(cdb_valid), .cdb(cdb), .cdb_ready(cdb_ready),
      .medium_present(medium_present), .medium_ascq(8'h3A),
      .last_lba(CAPW[63:32]), .block_len(CAPW[31:0]), .wcd(wcd),
      .power_perf(power_perf), .cap_valid(cap_valid),
      .cap_byte(cap_byte), .cap_ready(cap_rdy), .sts_valid(sts_valid),
      .sts_code(sts_code), .sense_key(sense_key), .asc(asc),
      .ascq(ascq), .med_req(med_req), .med_act(med_act),
      .med_done(med_done), .unit_ready(unit_ready),
      .pwr_cond(pwr_cond), .pwr_rank(pwr_rank), .need_rank(2'h3),
      .need_ok(need_ok), .dirty(dirty), .cache_wr_req(cwr_req),
      .cache_wr_idx(cwr_idx), .cache_wr_ack(cwr_ack),
      .wr_cache_done(wcd_c), .wr_media_done(wmd), .wr_good(wr_good));
   cpc_far_model cpc_far_model_i (.clk(clk), .nrst(nrst), .slow(slow),
      .mark(mark), .wr_req(cwr_req), .wr_idx(cwr_idx), .wr_ack(cwr_ack),
      .dirty(dirty), .writes(writes), .med_req(med_req),
      .med_done(med_done));
   // ----
   // Tasks
   // ----
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", s, e, g);
      end
   endtask
   task automatic sts(input logic [3:0] k, input logic [7:0] a,
      input logic [7:0] q);
      chk("sts_code", (k == SK_NONE) ? ST_GOOD : ST_CHECK, sts_code);
      chk("sense_key", k, sense_key);
      chk("asc", a, asc);
      chk("ascq", q, ascq);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] b1,
      input logic [7:0] b4);
      int n;
      n = 0;
      caps.delete();
      @(posedge clk);
      cdb_valid <= 1'b1;
      cdb <= {8'h00, 32'h0, b4, 16'h0, b1, op};
      @(negedge clk);
      while (cdb_ready !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      cdb_valid <= 1'b0;
      do begin
         @(negedge clk);
         if ((cap_valid & cap_rdy) === 1'b1) caps.push_back(cap_byte);
         n++;
      end while (sts_valid !== 1'b1 && n < 600);
      chk("sts_valid", 1, sts_valid);
   endtask
   task automatic rst();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
   endtask
   task automatic dirt(input logic [3:0] m);
      @(posedge clk);
      mark <= m;
      @(posedge clk);
      mark <= 4'h0;
   endtask
   task automatic wr(input bit media, input logic e);
      @(posedge clk);
      wmd <= media;
      wcd_c <= !media;
      @(posedge clk);
      wmd <= 1'b0;
      wcd_c <= 1'b0;
      @(negedge clk);
      chk("wr_good", e, wr_good);
   endtask
   task automatic results();
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cap_rdy <= !slow || !cap_rdy;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   // ----
   // Tests
   // ----
   initial begin
      nrst = 1'b0;
      cdb_valid = 1'b0;
      cdb = '0;
      medium_present = 1'b1;
      wcd = 1'b0;
      slow = 1'b0;
      power_perf = 8'h00;
      mark = 4'h0;
      wcd_c = 1'b0;
      wmd = 1'b0;
      rst();
      chk("pwr_cond", PC_ACTIVE, pwr_cond);
      chk("need_ok", 1, need_ok);
      cmd(OP_CAP, 8'h00, 8'h00);
      chk("cap_count", 8, caps.size());
      for (int i = 0; i < 8; i++)
         chk("cap", CAPW[63-8*i -: 8], caps[i]);
      sts(SK_NONE, ASC_NONE, 8'h00);
      @(posedge clk);
      medium_present <= 1'b0;
      cmd(OP_CAP, 8'h00, 8'h00);
      sts(SK_NOT_READY, ASC_NOT_READY, 8'h3A);
      @(posedge clk);
      medium_present <= 1'b1;
      $display("test capacity done");
      foreach (rsv[i]) begin
         cmd(OP_SSU, 8'h00, {rsv[i], 4'h0});
         sts(SK_ILLEGAL, ASC_BAD_FIELD, 8'h00);
         chk("pwr_cond", PC_ACTIVE, pwr_cond);
      end
      for (int i = 0; i < 2; i++) begin
         cmd(OP_SSU, 8'h00, {PC_IDLE, 4'h2});
         sts(SK_NONE, ASC_NONE, 8'h00);
         chk("pwr_cond", PC_IDLE, pwr_cond);
         chk("unit_ready", 1, unit_ready);
      end
      cmd(OP_SSU, 8'h00, {PC_DEVCTL, 4'h0});
      chk("pwr_rank", RANK_IDLE, pwr_rank);
      @(posedge clk);
      power_perf <= 8'h40;
      @(negedge clk);
      chk("pwr_rank", RANK_ACTIVE, pwr_rank);
      cmd(OP_SSU, 8'h00, {PC_ACTIVE, 4'h0});
      $display("test power codes done");
      slow <= 1'b1;
      dirt(4'hA);
      cmd(OP_SYNC, 8'h00, 8'h00);
      sts(SK_NONE, ASC_NONE, 8'h00);
      chk("writes", 2, writes);
      @(posedge clk);
      wcd <= 1'b1;
      cmd(OP_SYNC, 8'h00, 8'h00);
      sts(SK_ILLEGAL, ASC_BAD_OP, 8'h00);
      wr(1'b0, 1'b0);
      wr(1'b1, 1'b1);
      @(posedge clk);
      wcd <= 1'b0;
      wr(1'b0, 1'b1);
      dirt(4'h1);
      cmd(OP_SSU, 8'h00, {PC_STANDBY, 4'h0});
      chk("writes", 3, writes);
      chk("pwr_cond", PC_STANDBY, pwr_cond);
      chk("need_ok", 0, need_ok);
      cmd(OP_CAP, 8'h00, 8'h00);
      sts(SK_NONE, ASC_NONE, 8'h00);
      chk("cap_count", 8, caps.size());
      cmd(OP_SYNC, 8'h00, 8'h00);
      sts(SK_ILLEGAL, ASC_LOW_PWR, ASCQ_LOW_PWR);
      cmd(OP_SSU, 8'h00, {PC_ACTIVE, 4'h0});
      $display("test cache done");
      for (int i = 0; i < 4; i++) begin
         cmd(OP_SSU, 8'h00, {6'h0, i[1:0]});
         chk("med_act", i[1:0], med_act);
         chk("unit_ready", i[0], unit_ready);
         if (i == 0) cmd(OP_CAP, 8'h00, 8'h00);
         if (i == 0) sts(SK_NOT_READY, ASC_NOT_READY, 8'h3A);
      end
      $display("test motion done");
      dirt(4'hF);
      cmd(OP_SSU, 8'h01, {PC_STANDBY, 4'h0});
      sts(SK_NONE, ASC_NONE, 8'h00);
      chk("pwr_cond", PC_ACTIVE, pwr_cond);
      cmd(OP_SSU, 8'h00, {PC_SLEEP, 4'h0});
      chk("writes", 7, writes);
      chk("pwr_cond", PC_SLEEP, pwr_cond);
      chk("need_ok", 0, need_ok);
      cmd(OP_CAP, 8'h00, 8'h00);
      sts(SK_ILLEGAL, ASC_LOW_PWR, ASCQ_LOW_PWR);
      rst();
      chk("pwr_cond", PC_ACTIVE, pwr_cond);
      $display("test sleep done");
      results();
   end
endmodule

// file: include/cpc_flush_if.sv
// Purpose: Start/done link between command decoder and flush engine
// Assumes: One clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
interface cpc_flush_if;
   logic start;
   logic done;
   logic busy;
   modport ctl (output start, input done, input busy);
   modport eng (input start, output done, output busy);
endinterface

// file: include/cpc_pkg.sv
// Purpose: Constants and types for the capacity/power/cache command block
// Assumes: Command descriptors arrive whole, byte k at bits 8k+7..8k
// Notes: Sense key NONE with status GOOD marks a successful command
// Operation
// - Capacity query is opcode 25h, ten bytes, last byte is control
// - All eight capacity bytes go out before GOOD status
// - Capacity data: last block address then block length, MSB first
// - No medium: CHECK, NOT READY, unit-not-ready, state qualifier
// - Start/stop is opcode 1Bh; byte four holds power, loej, start
// - Immediate flag: status after validation, else after completion
// - Valid nonzero power code makes start and loej ignored
// - Power codes 0,1,2,3,5 mandatory, 7 optional, rest reserved
// - Dirty cached blocks reach the medium before Standby or Sleep
// - Device-controlled level is bounded by the power/performance setting
// - Commands needing more power than allowed end with low-power sense
// - Requesting the current power condition is not an error
// - With code zero: 00 stop, 01 ready, 10 unload, 11 load
// - No loej means no medium motion; stopped medium blocks transfers
// - Cache synchronize, opcode 35h, writes every newer cached block
// - Flushed blocks may remain valid in cache
// - With write caching disabled, synchronize may fail as invalid opcode
// - After Sleep, access may be refused until device reset
// - Write cache disabled: write GOOD only once data reaches medium
package cpc_pkg;
   // -------------------------------------------------------------
   // Opcodes and descriptor fields
   // -------------------------------------------------------------
   localparam logic [7:0] OP_CAP = 8'h25;
   localparam logic [7:0] OP_SSU = 8'h1B;
   localparam logic [7:0] OP_SYNC = 8'h35;
   localparam int SSU_BYTE = 4;
   localparam int PC_MSB = 7;
   localparam int PC_LSB = 4;
   localparam int LOEJ_BIT = 1;
   localparam int START_BIT = 0;
   localparam int IMM_BYTE = 1;
   localparam int IMM_BIT = 0;
   // -------------------------------------------------------------
   // Power condition codes and allowance ranks
   // -------------------------------------------------------------
   localparam logic [3:0] PC_NOCHG = 4'h0;
   localparam logic [3:0] PC_ACTIVE = 4'h1;
   localparam logic [3:0] PC_IDLE = 4'h2;
   localparam logic [3:0] PC_STANDBY = 4'h3;
   localparam logic [3:0] PC_SLEEP = 4'h5;
   localparam logic [3:0] PC_DEVCTL = 4'h7;
   localparam logic [1:0] RANK_SLEEP = 2'h0;
   localparam logic [1:0] RANK_STANDBY = 2'h1;
   localparam logic [1:0] RANK_IDLE = 2'h2;
   localparam logic [1:0] RANK_ACTIVE = 2'h3;
   localparam logic [1:0] CAP_NEED = 2'h1;
   localparam logic [1:0] SYNC_NEED = 2'h2;
   // -------------------------------------------------------------
   // Status and sense codes
   // -------------------------------------------------------------
   localparam logic [7:0] ST_GOOD = 8'h00;
   localparam logic [7:0] ST_CHECK = 8'h02;
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_NOT_READY = 4'h2;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_NOT_READY = 8'h04;
   localparam logic [7:0] ASC_LOW_PWR = 8'h5E;
   localparam logic [7:0] ASCQ_LOW_PWR = 8'h00;
   localparam logic [7:0] ASC_BAD_OP = 8'h20;
   localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
   // -------------------------------------------------------------
   // Capacity transfer and resets
   // -------------------------------------------------------------
   localparam logic [2:0] CAP_LAST = 3'h7;
   localparam logic [3:0] PWR_RST = 4'h1;
   typedef enum logic [1:0] {S_IDLE, S_XFER, S_FLUSH, S_MED} cpc_state_t;
endpackage

// file: src/cpc_flush.sv
// Purpose: Walks the dirty map and writes each dirty block to the medium
// Assumes: Cache clears a dirty bit itself after acknowledging its write
// Notes: Blocks stay valid in cache; nothing is evicted
`timescale 1ns/1ps
module cpc_flush import cpc_pkg::*; #(
   parameter int NBLK = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   cpc_flush_if.eng fl,
   // Cache write port
   input wire logic [NBLK-1:0] dirty,
   output logic wr_req,
   output logic [$clog2(NBLK)-1:0] wr_idx,
   input wire logic wr_ack
);
   localparam int IW = $clog2(NBLK);
   localparam logic [IW-1:0] LAST = IW'(NBLK - 1);
   logic busy_q;
   logic done_q;
   logic req_q;
   logic [IW-1:0] idx_q;
   logic step;

   // -------------------------------------------------------------
   // Scan
   // -------------------------------------------------------------
   assign step = busy_q && ((req_q && wr_ack) || (!req_q && !dirty[idx_q]));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         idx_q <= '0;
      end else begin
         done_q <= 1'b0;
         if (fl.start && !busy_q) begin
            busy_q <= 1'b1;
            idx_q <= '0;
         end else if (step) begin
            if (idx_q == LAST) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               idx_q <= idx_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q <= 1'b0;
      end else if (req_q && wr_ack) begin
         req_q <= 1'b0;
      end else if (busy_q && !req_q && dirty[idx_q]) begin
         req_q <= 1'b1;
      end
   end

   assign wr_req = req_q;
   assign wr_idx = idx_q;
   assign fl.done = done_q;
   assign fl.busy = busy_q;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   req_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      wr_req && !wr_ack |=> wr_req && $stable(wr_idx))
      else $error("flush write request dropped before ack");
endmodule

// file: src/cpc_top.sv
// Purpose: Decodes capacity, start/stop and cache synchronize commands
// Assumes: Command and medium sides are logic on the same clock
// Notes: Sleep is left only through nrst
`timescale 1ns/1ps
module cpc_top import cpc_pkg::*; #(
   parameter int NBLK = 16,
   parameter bit DC_SUPPORT = 1'b1,
   parameter bit SYNC_WCD_REJECT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Command in
   input wire logic cdb_valid,
   input wire logic [79:0] cdb,
   output logic cdb_ready,
   // Medium and configuration
   input wire logic medium_present,
   input wire logic [7:0] medium_ascq,
   input wire logic [31:0] last_lba,
   input wire logic [31:0] block_len,
   input wire logic wcd,
   input wire logic [7:0] power_perf,
   // Capacity data out
   output logic cap_valid,
   output logic [7:0] cap_byte,
   input wire logic cap_ready,
   // Status out
   output logic sts_valid,
   output logic [7:0] sts_code,
   output logic [3:0] sense_key,
   output logic [7:0] asc,
   output logic [7:0] ascq,
   // Medium control
   output logic med_req,
   output logic [1:0] med_act,
   input wire logic med_done,
   output logic unit_ready,
   // Power allowance for other commands
   output logic [3:0] pwr_cond,
   output logic [1:0] pwr_rank,
   input wire logic [1:0] need_rank,
   output logic need_ok,
   // Cache write port
   input wire logic [NBLK-1:0] dirty,
   output logic cache_wr_req,
   output logic [$clog2(NBLK)-1:0] cache_wr_idx,
   input wire logic cache_wr_ack,
   // Write completion
   input wire logic wr_cache_done,
   input wire logic wr_media_done,
   output logic wr_good
);
   cpc_state_t st_q;
   cpc_state_t nxt;
   logic [3:0] pwr_q;
   logic [3:0] tgt_q;
   logic imm_q;
   logic rdy_q;
   logic [63:0] cap_q;
   logic [2:0] cnt_q;
   logic [1:0] act_q;
   logic mreq_q;
   logic sv_q;
   logic [3:0] sk_q;
   logic [7:0] asc_q;
   logic [7:0] ascq_q;
   logic wg_q;
   logic acc;
   logic [7:0] opc;
   logic [3:0] pc;
   logic imm;
   logic pc_ok;
   logic sleep;
   logic [1:0] rank;
   logic rep;
   logic [3:0] rk;
   logic [7:0] ra;
   logic [7:0] rq;
   logic go_fl;
   logic go_med;
   logic set_pw;
   logic [3:0] new_pw;
   logic ld_cap;

   cpc_flush_if fl ();

   cpc_flush #(.NBLK(NBLK)) u_flush (
      .clk(clk),
      .nrst(nrst),
      .fl(fl),
      .dirty(dirty),
      .wr_req(cache_wr_req),
      .wr_idx(cache_wr_idx),
      .wr_ack(cache_wr_ack)
   );

   // -------------------------------------------------------------
   // Field decode
   // -------------------------------------------------------------
   assign cdb_ready = (st_q == S_IDLE);
   assign acc = cdb_valid && cdb_ready;
   assign opc = cdb[7:0];
   assign pc = cdb[8*SSU_BYTE+PC_LSB +: 4];
   assign imm = cdb[8*IMM_BYTE+IMM_BIT];
   assign sleep = (pwr_q == PC_SLEEP);

   always_comb begin
      case (pc)
         PC_NOCHG, PC_ACTIVE, PC_IDLE, PC_STANDBY, PC_SLEEP: pc_ok = 1'b1;
         PC_DEVCTL: pc_ok = DC_SUPPORT;
         default: pc_ok = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // Power allowance
   // -------------------------------------------------------------
   always_comb begin
      case (pwr_q)
         PC_ACTIVE: rank = RANK_ACTIVE;
         PC_IDLE: rank = RANK_IDLE;
         PC_STANDBY: rank = RANK_STANDBY;
         PC_DEVCTL: begin
            rank = (power_perf != 8'h00) ? RANK_ACTIVE : RANK_IDLE;
         end
         default: rank = RANK_SLEEP;
      endcase
   end

   assign pwr_rank = rank;
   assign need_ok = !sleep && (need_rank <= rank);
   assign pwr_cond = pwr_q;

   // -------------------------------------------------------------
   // Command decision
   // -------------------------------------------------------------
   always_comb begin
      nxt = st_q;
      rep = 1'b0;
      rk = SK_NONE;
      ra = ASC_NONE;
      rq = ASC_NONE;
      go_fl = 1'b0;
      go_med = 1'b0;
      set_pw = 1'b0;
      new_pw = pwr_q;
      ld_cap = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (acc) begin
               rep = 1'b1;
               case (opc)
                  OP_CAP: begin
                     if (sleep || rank < CAP_NEED) begin
                        rk = SK_ILLEGAL;
                        ra = ASC_LOW_PWR;
                        rq = ASCQ_LOW_PWR;
                     end else if (!medium_present || !rdy_q) begin
                        rk = SK_NOT_READY;
                        ra = ASC_NOT_READY;
                        rq = medium_ascq;
                     end else begin
                        rep = 1'b0;
                        ld_cap = 1'b1;
                        nxt = S_XFER;
                     end
                  end
                  OP_SSU: begin
                     if (sleep) begin
                        rk = SK_ILLEGAL;
                        ra = ASC_LOW_PWR;
                        rq = ASCQ_LOW_PWR;
                     end else if (!pc_ok) begin
                        rk = SK_ILLEGAL;
                        ra = ASC_BAD_FIELD;
                     end else if (pc != PC_NOCHG) begin
                        if (pc == pwr_q) begin
                           rep = 1'b1;
                        end else if (pc == PC_STANDBY || pc == PC_SLEEP) begin
                           go_fl = 1'b1;
                           rep = imm;
                           nxt = S_FLUSH;
                        end else begin
                           set_pw = 1'b1;
                           new_pw = pc;
                        end
                     end else begin
                        go_med = 1'b1;
                        rep = imm;
                        nxt = S_MED;
                     end
                  end
                  OP_SYNC: begin
                     if (wcd && SYNC_WCD_REJECT) begin
                        rk = SK_ILLEGAL;
                        ra = ASC_BAD_OP;
                     end else if (sleep || rank < SYNC_NEED) begin
                        rk = SK_ILLEGAL;
                        ra = ASC_LOW_PWR;
                        rq = ASCQ_LOW_PWR;
                     end else begin
                        rep = 1'b0;
                        go_fl = 1'b1;
                        nxt = S_FLUSH;
                     end
                  end
                  default: begin
                     rk = SK_ILLEGAL;
                     ra = ASC_BAD_OP;
                  end
               endcase
            end
         end
         S_XFER: begin
            if (cap_ready && cnt_q == CAP_LAST) begin
               rep = 1'b1;
               nxt = S_IDLE;
            end
         end
         S_FLUSH: begin
            if (fl.done) begin
               set_pw = 1'b1;
               new_pw = tgt_q;
               rep = !imm_q;
               nxt = S_IDLE;
            end
         end
         S_MED: begin
            if (med_done) begin
               rep = !imm_q;
               nxt = S_IDLE;
            end
         end
         default: nxt = S_IDLE;
      endcase
   end

   // -------------------------------------------------------------
   // State and power
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
      end else begin
         st_q <= nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= PWR_RST;
      end else if (set_pw) begin
         pwr_q <= new_pw;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tgt_q <= PWR_RST;
         imm_q <= 1'b0;
      end else if (acc) begin
         tgt_q <= (opc == OP_SSU) ? pc : pwr_q;
         imm_q <= (opc == OP_SSU) && imm;
      end
   end

   assign fl.start = go_fl;

   // -------------------------------------------------------------
   // Medium control
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mreq_q <= 1'b0;
         act_q <= 2'h0;
      end else begin
         mreq_q <= go_med;
         if (go_med) begin
            act_q <= {cdb[8*SSU_BYTE+LOEJ_BIT], cdb[8*SSU_BYTE+START_BIT]};
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdy_q <= 1'b1;
      end else if (st_q == S_MED && med_done) begin
         rdy_q <= act_q[START_BIT];
      end
   end

   assign med_req = mreq_q;
   assign med_act = act_q;
   assign unit_ready = rdy_q;

   // -------------------------------------------------------------
   // Capacity data
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_q <= '0;
         cnt_q <= 3'h0;
      end else if (ld_cap) begin
         cap_q <= {last_lba, block_len};
         cnt_q <= 3'h0;
      end else if (st_q == S_XFER && cap_ready) begin
         cap_q <= {cap_q[55:0], 8'h00};
         cnt_q <= cnt_q + 3'h1;
      end
   end

   assign cap_valid = (st_q == S_XFER);
   assign cap_byte = cap_q[63:56];

   // -------------------------------------------------------------
   // Status
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sv_q <= 1'b0;
         sk_q <= SK_NONE;
         asc_q <= ASC_NONE;
         ascq_q <= ASC_NONE;
      end else begin
         sv_q <= rep;
         if (rep) begin
            sk_q <= rk;
            asc_q <= ra;
            ascq_q <= rq;
         end
      end
   end

   assign sts_valid = sv_q;
   assign sense_key = sk_q;
   assign asc = asc_q;
   assign ascq = ascq_q;
   assign sts_code = (sk_q == SK_NONE) ? ST_GOOD : ST_CHECK;

   // -------------------------------------------------------------
   // Write completion
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wg_q <= 1'b0;
      end else begin
         wg_q <= wcd ? wr_media_done : wr_cache_done;
      end
   end

   assign wr_good = wg_q;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   cap_order_a: assert property (@(posedge clk) disable iff (!nrst)
      cap_valid && cap_ready && cnt_q == CAP_LAST
      |=> sts_valid && sts_code == ST_GOOD && !cap_valid)
      else $error("capacity status not after last byte");
   cap_first_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(cap_valid) |-> cap_byte == $past(last_lba[31:24]))
      else $error("capacity data not address MSB first");
   no_medium_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_CAP && !sleep && rank >= CAP_NEED && !medium_present
      |=> sts_valid && sense_key == SK_NOT_READY
          && asc == ASC_NOT_READY && ascq == $past(medium_ascq))
      else $error("missing not-ready sense for capacity");
   imm_early_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_SSU && !sleep && imm && pc != pwr_q
      && (pc == PC_NOCHG || pc == PC_STANDBY || pc == PC_SLEEP)
      |=> sts_valid ##1 !sts_valid)
      else $error("immediate status not reported at once");
   pc_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_SSU && pc != PC_NOCHG |=> !med_req)
      else $error("start or loej acted on with power code");
   flush_first_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(pwr_cond) && (pwr_cond == PC_STANDBY || pwr_cond == PC_SLEEP)
      |-> $past(fl.done))
      else $error("low power entered before cache flush");
   low_power_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_SYNC && !wcd && rank < SYNC_NEED
      |=> sense_key == SK_ILLEGAL && asc == ASC_LOW_PWR)
      else $error("low power rejection missing");
   same_pwr_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_SSU && !sleep && pc_ok && pc == pwr_q
      |=> sts_valid && sts_code == ST_GOOD)
      else $error("same power request reported as error");
   sleep_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      pwr_cond == PC_SLEEP |=> pwr_cond == PC_SLEEP)
      else $error("sleep left without reset");
   wr_media_a: assert property (@(posedge clk) disable iff (!nrst)
      wcd && !wr_media_done |=> !wr_good)
      else $error("write good before medium with cache off");
   bad_pc_a: assert property (@(posedge clk) disable iff (!nrst)
      acc && opc == OP_SSU && !sleep && !pc_ok
      |=> sense_key == SK_ILLEGAL && asc == ASC_BAD_FIELD
          && $stable(pwr_cond))
      else $error("reserved power code not rejected");
endmodule
